// ---- rtl/tmz_timer.sv ----
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module tmz_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // clock sources and sleep
  input wire tmz_pkg::tmz_clk_in_t i_clk_in,
  input wire logic i_sleep,
  // outputs and flag clear
  output logic o_match_pulse,
  output logic o_timer_out,
  output logic o_timer_flag,
  input wire logic i_flag_clear
);
  import tmz_pkg::*;

  tmz_ctrl0_t ctrl0_reg;
  tmz_ctrl1_t ctrl1_reg;
  logic [7:0] low_reg;
  logic [7:0] high_buf_reg;
  logic [7:0] high_true_reg;
  logic [7:0] period_buf_reg;
  logic [14:0] pre_reg;
  logic [3:0] post_reg;
  logic src_sync1_reg;
  logic src_sync2_reg;
  logic src_prev_reg;
  logic raw_src;
  logic src_level;
  logic src_rise;
  logic pre_tick;
  logic count_en;
  logic event_hit;
  logic post_tick;
  logic wr_low;
  logic wr_high;
  logic wr_c0;
  logic wr_c1;
  logic scaler_clr;
  logic instr_tick;
  logic run;

  function automatic logic [14:0] tmz_pre_mask(input logic [3:0] sel);
    tmz_pre_mask = 15'((16'h0001 << sel) - 16'h0001);
  endfunction : tmz_pre_mask

  assign wr_low = i_wr && (i_addr == TMZ_OFF_COUNT_LOW);
  assign wr_high = i_wr && (i_addr == TMZ_OFF_COUNT_HIGH);
  assign wr_c0 = i_wr && (i_addr == TMZ_OFF_CTRL0);
  assign wr_c1 = i_wr && (i_addr == TMZ_OFF_CTRL1);
  assign scaler_clr = wr_low || wr_c0 || wr_c1;
  // sleep halts synchronous counting only
  assign run = ctrl0_reg.enable && (ctrl1_reg.async_select || !i_sleep);

  // source mux
  always_comb begin
    unique case (ctrl1_reg.clock_source_select)
      TMZ_SRC_PIN_TRUE: raw_src = i_clk_in.count_input_pin;
      TMZ_SRC_PIN_INV: raw_src = ~i_clk_in.count_input_pin;
      TMZ_SRC_INSTR: raw_src = 1'b0;
      TMZ_SRC_HFOSC: raw_src = i_clk_in.high_freq_osc;
      TMZ_SRC_LFOSC: raw_src = i_clk_in.low_freq_osc;
      TMZ_SRC_MFOSC: raw_src = i_clk_in.medium_freq_osc;
      TMZ_SRC_RSVD: raw_src = 1'b0;
      TMZ_SRC_LCELL: raw_src = i_clk_in.logic_cell_output;
    endcase
  end

  // with one clock, async bypasses the two-stage synchroniser, saving latency
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      src_sync1_reg <= 1'b0;
      src_sync2_reg <= 1'b0;
    end else begin
      src_sync1_reg <= raw_src;
      src_sync2_reg <= src_sync1_reg;
    end
  end

  assign src_level = ctrl1_reg.async_select ? raw_src : src_sync2_reg;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  // i_clk is the instruction clock, so instruction source ticks every cycle
  assign instr_tick = (ctrl1_reg.clock_source_select == TMZ_SRC_INSTR);
  assign src_rise = instr_tick || (src_level && !src_prev_reg);

  // prescaler
  assign pre_tick = run && src_rise;
  assign count_en = pre_tick && ((pre_reg & tmz_pre_mask(ctrl1_reg.prescale_select))
                    == tmz_pre_mask(ctrl1_reg.prescale_select));

  always_ff @(posedge i_clk) begin
    if (!i_resetn || scaler_clr) begin
      pre_reg <= 15'h0000;
    end else if (pre_tick) begin
      pre_reg <= count_en ? 15'h0000 : pre_reg + 15'h0001;
    end
  end

  // match or rollover
  assign event_hit = count_en && (ctrl0_reg.width_select
                     ? ({high_true_reg, low_reg} == 16'hffff)
                     : (low_reg == period_buf_reg));

  // postscaler
  assign post_tick = event_hit && (post_reg == ctrl0_reg.postscale_select);

  always_ff @(posedge i_clk) begin
    if (!i_resetn || scaler_clr) begin
      post_reg <= 4'h0;
    end else if (event_hit) begin
      post_reg <= post_tick ? 4'h0 : post_reg + 4'h1;
    end
  end

  // control registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl0_reg <= tmz_ctrl0_t'(TMZ_RST_CTRL[5:0]);
      ctrl1_reg <= tmz_ctrl1_t'(TMZ_RST_CTRL);
    end else begin
      if (wr_c0) begin
        ctrl0_reg <= {i_wdata[TMZ_C0_ENABLE], i_wdata[TMZ_C0_WIDTH], i_wdata[3:0]};
      end
      if (wr_c1) begin
        ctrl1_reg <= tmz_ctrl1_t'(i_wdata);
      end
    end
  end

  // low count byte
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      low_reg <= TMZ_RST_LOW;
    end else if (wr_low) begin
      low_reg <= i_wdata;
    end else if (count_en) begin
      if (!ctrl0_reg.width_select && event_hit) begin
        low_reg <= 8'h00;
      end else begin
        low_reg <= low_reg + 8'h01;
      end
    end
  end

  // high buffer: plain period register in 8-bit mode
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      high_buf_reg <= TMZ_RST_HIGH;
    end else if (wr_high) begin
      high_buf_reg <= i_wdata;
    end else if (i_rd && i_addr == TMZ_OFF_COUNT_LOW && ctrl0_reg.width_select) begin
      high_buf_reg <= high_true_reg;
    end
  end

  // true high byte, never on the register port
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      high_true_reg <= 8'h00;
    end else if (wr_low && ctrl0_reg.width_select) begin
      high_true_reg <= high_buf_reg;
    end else if (count_en && ctrl0_reg.width_select && low_reg == 8'hff) begin
      high_true_reg <= high_true_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      period_buf_reg <= TMZ_RST_HIGH;
    end else if (!ctrl0_reg.width_select && event_hit) begin
      period_buf_reg <= high_buf_reg;
    end
  end

  // output pulse lasts until the next prescaled count enable
  always_ff @(posedge i_clk) begin
    if (!i_resetn || scaler_clr) begin
      o_match_pulse <= 1'b0;
    end else if (count_en) begin
      o_match_pulse <= post_tick;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_timer_out <= 1'b0;
    end else if (post_tick) begin
      o_timer_out <= ~o_timer_out;
    end
  end

  // set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_timer_flag <= 1'b0;
    end else if (post_tick) begin
      o_timer_flag <= 1'b1;
    end else if (i_flag_clear) begin
      o_timer_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        TMZ_OFF_COUNT_LOW: o_rdata <= low_reg;
        TMZ_OFF_COUNT_HIGH: o_rdata <= high_buf_reg;
        TMZ_OFF_CTRL0: o_rdata <= {ctrl0_reg.enable, 1'b0, o_timer_out,
                                   ctrl0_reg.width_select, ctrl0_reg.postscale_select};
        TMZ_OFF_CTRL1: o_rdata <= ctrl1_reg;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  a_reset_values: assert property (@(posedge i_clk)
    !i_resetn |=> (low_reg == 8'h00 && high_buf_reg == 8'hff))
    else $error("reset values wrong");
  a_scaler_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    scaler_clr |=> (pre_reg == 15'h0000 && post_reg == 4'h0))
    else $error("scalers not cleared");
  a_match_reload: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (event_hit && !ctrl0_reg.width_select && !wr_low) |=> low_reg == 8'h00)
    else $error("low count not cleared on match");
  a_read_latch: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == TMZ_OFF_COUNT_LOW && ctrl0_reg.width_select && !i_wr)
    |=> high_buf_reg == $past(high_true_reg))
    else $error("high buffer not latched");
  a_write_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (wr_low && ctrl0_reg.width_select) |=> high_true_reg == $past(high_buf_reg))
    else $error("true high not loaded");
  a_instr_rate: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (instr_tick && run && ctrl1_reg.prescale_select == 4'h0 && !i_wr)
    |-> count_en)
    else $error("no count at 1:1");
  a_toggle_out: assert property (@(posedge i_clk) disable iff (!i_resetn)
    post_tick |=> o_timer_out != $past(o_timer_out))
    else $error("output did not toggle");
  a_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
    post_tick |=> o_timer_flag)
    else $error("flag not set");
  a_post_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    post_reg <= ctrl0_reg.postscale_select || scaler_clr || $changed(ctrl0_reg))
    else $error("postscaler overran");
  a_prescale_gap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (count_en && instr_tick && ctrl1_reg.prescale_select == 4'h1 && run)
    |=> !count_en)
    else $error("prescaler 1:2 wrong");
  // register port and coherent access bookkeeping
  a_low_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_low
    |=> low_reg == $past(i_wdata))
    else $error("low count write lost");
  a_high_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr_high
    |=> high_buf_reg == $past(i_wdata))
    else $error("high buffer write lost");
  a_high_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == TMZ_OFF_COUNT_HIGH)
    |=> o_rdata == $past(high_buf_reg))
    else $error("high buffer read wrong");
  a_ctrl1_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_rd && i_addr == TMZ_OFF_CTRL1)
    |=> o_rdata == $past(ctrl1_reg))
    else $error("second control read wrong");
  a_period_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (event_hit && !ctrl0_reg.width_select)
    |=> period_buf_reg == $past(high_buf_reg))
    else $error("period buffer not reloaded");
  a_roll_carry: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (count_en && ctrl0_reg.width_select && low_reg == 8'hff && !wr_low)
    |=> high_true_reg == $past(high_true_reg) + 8'h01)
    else $error("high byte did not carry");
  // match pulse, flag, output and sleep behaviour
  a_pulse_rise: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (count_en && post_tick && !scaler_clr)
    |=> o_match_pulse)
    else $error("match pulse missing");
  a_pulse_drop: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (count_en && !post_tick && !scaler_clr)
    |=> !o_match_pulse)
    else $error("match pulse too long");
  a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_timer_flag && i_flag_clear && !post_tick)
    |=> !o_timer_flag)
    else $error("flag not cleared");
  a_flag_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_timer_flag && !i_flag_clear)
    |=> o_timer_flag)
    else $error("flag dropped by itself");
  a_out_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !post_tick
    |=> o_timer_out == $past(o_timer_out))
    else $error("output toggled without event");
  a_sleep_halt: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_sleep && !ctrl1_reg.async_select)
    |-> !count_en)
    else $error("synchronous count in sleep");

  c_match_8bit: cover property (@(posedge i_clk) event_hit && !ctrl0_reg.width_select);
  c_roll_16bit: cover property (@(posedge i_clk) event_hit && ctrl0_reg.width_select);
  c_flag_clear: cover property (@(posedge i_clk) o_timer_flag && i_flag_clear);
  c_async_sleep: cover property (@(posedge i_clk) count_en && i_sleep);
  c_prescaled: cover property (@(posedge i_clk) count_en && ctrl1_reg.prescale_select != 4'h0);
endmodule : tmz_timer

// ---- rtl/tmz_pkg.sv ----
package tmz_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] TMZ_OFF_COUNT_LOW = 2'h0;
  localparam logic [1:0] TMZ_OFF_COUNT_HIGH = 2'h1;
  localparam logic [1:0] TMZ_OFF_CTRL0 = 2'h2;
  localparam logic [1:0] TMZ_OFF_CTRL1 = 2'h3;
  // first control register fields
  localparam int TMZ_C0_ENABLE = 7;
  localparam int TMZ_C0_OUTBIT = 5;
  localparam int TMZ_C0_WIDTH = 4;
  // reset values
  localparam logic [7:0] TMZ_RST_LOW = 8'h00;
  localparam logic [7:0] TMZ_RST_HIGH = 8'hff;
  localparam logic [7:0] TMZ_RST_CTRL = 8'h00;

  typedef enum logic [2:0] {
    TMZ_SRC_PIN_TRUE,
    TMZ_SRC_PIN_INV,
    TMZ_SRC_INSTR,
    TMZ_SRC_HFOSC,
    TMZ_SRC_LFOSC,
    TMZ_SRC_MFOSC,
    TMZ_SRC_RSVD,
    TMZ_SRC_LCELL
  } tmz_src_t;

  typedef struct packed {
    logic enable;
    logic width_select;
    logic [3:0] postscale_select;
  } tmz_ctrl0_t;

  typedef struct packed {
    tmz_src_t clock_source_select;
    logic async_select;
    logic [3:0] prescale_select;
  } tmz_ctrl1_t;

  typedef struct packed {
    logic count_input_pin;
    logic high_freq_osc;
    logic low_freq_osc;
    logic medium_freq_osc;
    logic logic_cell_output;
  } tmz_clk_in_t;
endpackage : tmz_pkg

// ---- testbench/tmz_pin_model.sv ----
`timescale 1ns/1ns
module tmz_pin_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // burst request
  input wire logic i_go,
  input wire logic [7:0] i_count,
  // pin side
  output logic o_pin,
  output logic o_busy
);
  logic [7:0] left_reg;
  logic [1:0] phase_reg;
  assign o_busy = (left_reg != 8'h00);
  // two cycles high, two low, so the pin never outruns the instruction clock
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      left_reg <= 8'h00;
      phase_reg <= 2'h0;
      o_pin <= 1'b0;
    end else if (i_go) begin
      left_reg <= i_count;
      phase_reg <= 2'h0;
    end else if (o_busy) begin
      phase_reg <= phase_reg + 2'h1;
      o_pin <= ~phase_reg[1];
      if (phase_reg == 2'h3) begin
        left_reg <= left_reg - 8'h01;
      end
    end else begin
      // the pin rests low between bursts
      o_pin <= 1'b0;
    end
  end
endmodule : tmz_pin_model

// ---- testbench/tmz_timer_bench.sv ----
`timescale 1ns/1ns
module tmz_timer_bench;
  import tmz_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic fclr = 1'b0;
  logic go = 1'b0;
  logic [7:0] npulse = 8'h00;
  logic [3:0] osc = 4'h0;
  logic [7:0] rdata;
  logic pin, busy, match, tout, flag;
  tmz_clk_in_t clk_in;
  int errors = 0;
  int tests_run = 0;
  // oscillators at fixed fractions of the clock, so edge counts are exact
  assign clk_in = {pin, osc[1], osc[3], osc[2], osc[1]};
  always #50 clk = ~clk;
  always @(posedge clk) osc <= osc + 4'h1;
  tmz_timer tmz_timer_i (.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_clk_in(clk_in), .i_sleep(sleep),
    .o_match_pulse(match), .o_timer_out(tout), .o_timer_flag(flag), .i_flag_clear(fclr));
  tmz_pin_model tmz_pin_model_i (.i_clk(clk), .i_resetn(resetn), .i_go(go),
    .i_count(npulse), .o_pin(pin), .o_busy(busy));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd_reg(a, r);
    check(r, exp);
  endtask : rd_chk
  task automatic clr_flag;
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    #1 check(flag, 1'b0);
  endtask : clr_flag
  // cycles until the next rising edge of the match pulse
  task automatic wait_rise(output int n);
    logic prev;
    logic hit;
    n = 0;
    hit = 1'b0;
    prev = match;
    while (!hit && n < 5000) begin
      @(negedge clk);
      n++;
      hit = (match === 1'b1 && prev === 1'b0);
      prev = match;
    end
  endtask : wait_rise
  // one whole match period, rising edge to rising edge
  task automatic gap(output int n);
    wait_rise(n);
    wait_rise(n);
  endtask : gap
  task automatic t_reset;
    resetn <= 1'b0;
    tick(12);
    resetn <= 1'b1;
    rd_chk(TMZ_OFF_COUNT_LOW, 8'h00);
    rd_chk(TMZ_OFF_COUNT_HIGH, 8'hff);
    rd_chk(TMZ_OFF_CTRL0, 8'h00);
    rd_chk(TMZ_OFF_CTRL1, 8'h00);
    check({match, flag}, 2'b00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_period;
    int n;
    logic t0;
    wr_reg(TMZ_OFF_COUNT_HIGH, 8'h04);
    rd_chk(TMZ_OFF_COUNT_HIGH, 8'h04);
    wr_reg(TMZ_OFF_COUNT_LOW, 8'h3c);
    rd_chk(TMZ_OFF_COUNT_LOW, 8'h3c);
    wr_reg(TMZ_OFF_CTRL1, 8'h40);
    wr_reg(TMZ_OFF_CTRL0, 8'h80);
    gap(n);
    tick(2);
    check(flag, 1'b1);
    clr_flag;
    gap(n);
    check(n, 5);
    // exactly one event falls in the next five cycles
    t0 = tout;
    repeat (5) @(negedge clk);
    check(tout ^ t0, 1'b1);
    wr_reg(TMZ_OFF_CTRL1, 8'h42);
    gap(n);
    check(n, 20);
    wr_reg(TMZ_OFF_CTRL1, 8'h40);
    wr_reg(TMZ_OFF_CTRL0, 8'h82);
    gap(n);
    check(n, 15);
    $display("period test done");
  endtask : t_period
  task automatic t_wide;
    int n;
    logic [7:0] r;
    clr_flag;
    wr_reg(TMZ_OFF_CTRL0, 8'h10);
    wr_reg(TMZ_OFF_COUNT_HIGH, 8'h12);
    wr_reg(TMZ_OFF_COUNT_LOW, 8'h34);
    wr_reg(TMZ_OFF_COUNT_HIGH, 8'h56);
    rd_chk(TMZ_OFF_COUNT_HIGH, 8'h56);
    rd_chk(TMZ_OFF_COUNT_LOW, 8'h34);
    rd_chk(TMZ_OFF_COUNT_HIGH, 8'h12);
    wr_reg(TMZ_OFF_COUNT_HIGH, 8'hff);
    wr_reg(TMZ_OFF_COUNT_LOW, 8'hfe);
    wr_reg(TMZ_OFF_CTRL0, 8'h90);
    wait_rise(n);
    check(n < 12, 1'b1);
    tick(2);
    check(flag, 1'b1);
    rd_reg(TMZ_OFF_CTRL0, r);
    check(r, {2'b10, tout, 5'h10});
    $display("wide test done");
  endtask : t_wide
  // pin counting: true, inverted, 1:2 prescale, sync in sleep, async in sleep
  task automatic t_pin;
    logic [7:0] c1 [5] = '{8'h00, 8'h20, 8'h01, 8'h00, 8'h10};
    logic sl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] ex [5] = '{8'h0a, 8'h0a, 8'h05, 8'h00, 8'h0a};
    logic [7:0] r;
    int i;
    for (int k = 0; k < 5; k++) begin
      wr_reg(TMZ_OFF_CTRL0, 8'h10);
      wr_reg(TMZ_OFF_COUNT_HIGH, 8'h00);
      wr_reg(TMZ_OFF_COUNT_LOW, 8'h00);
      wr_reg(TMZ_OFF_CTRL1, c1[k]);
      sleep <= sl[k];
      // let a new source level settle, so switching gives no false edge
      tick(3);
      wr_reg(TMZ_OFF_CTRL0, 8'h90);
      @(posedge clk);
      npulse <= 8'h0a;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      i = 0;
      while ((busy === 1'b1 || i < 2) && i < 600) begin
        @(negedge clk);
        i++;
      end
      tick(4);
      wr_reg(TMZ_OFF_CTRL0, 8'h10);
      sleep <= 1'b0;
      rd_reg(TMZ_OFF_COUNT_LOW, r);
      check(r, ex[k]);
    end
    $display("pin test done");
  endtask : t_pin
  // internal sources over a 64-cycle window; one count of slack for sync latency
  task automatic t_src;
    int ex [6] = '{64, 16, 4, 8, 0, 16};
    logic [7:0] r;
    int rv;
    for (int k = 0; k < 6; k++) begin
      wr_reg(TMZ_OFF_COUNT_LOW, 8'h00);
      wr_reg(TMZ_OFF_CTRL1, {3'(k + 2), 5'h00});
      wr_reg(TMZ_OFF_CTRL0, 8'h90);
      tick(62);
      wr_reg(TMZ_OFF_CTRL0, 8'h10);
      rd_reg(TMZ_OFF_COUNT_LOW, r);
      rv = r;
      check(rv >= ex[k] - 1 && rv <= ex[k] + 1, 1'b1);
    end
    $display("source test done");
  endtask : t_src
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    t_reset;
    t_period;
    t_wide;
    t_pin;
    t_src;
    wr_reg(TMZ_OFF_CTRL0, 8'h80);
    tick(20);
    t_reset;
    wrap_up;
  end
  initial begin
    #(100 * 30000);
    errors++;
    wrap_up;
  end
endmodule : tmz_timer_bench
